// ### clksw_edge_mon.sv
// edge and activity monitor for one sampled input clock
`timescale 1ns/1ps
`default_nettype none
module clksw_edge_mon (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic clk_sample,
   input wire logic amp_ok,
   output logic rise_q,
   output logic fall_q,
   output logic level_q,
   output logic stuck_q
);
   import clksw_pkg::*;
   logic prev_q;
   logic [7:0] idle_q;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         prev_q <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else if (ce) begin
         prev_q <= clk_sample;
         rise_q <= amp_ok & clk_sample & ~prev_q;
         fall_q <= amp_ok & ~clk_sample & prev_q;
      end
   end

   // level only moves while the swing is valid, so a dead input leaves the last good level
   always_ff @(posedge clk) begin
      if (!rstn) begin
         level_q <= 1'b0;
      end else if (ce && amp_ok) begin
         level_q <= clk_sample;
      end
   end

   // idle counter saturates; any edge restarts it
   always_ff @(posedge clk) begin
      if (!rstn) begin
         idle_q <= CNT_ZERO;
         stuck_q <= 1'b0;
      end else if (ce) begin
         if (!amp_ok || clk_sample != prev_q) begin
            idle_q <= CNT_ZERO;
         end else if (idle_q != STUCK_COUNT) begin
            idle_q <= idle_q + CNT_ONE;
         end
         stuck_q <= !amp_ok || (idle_q == STUCK_COUNT);
      end
   end
endmodule : clksw_edge_mon
`default_nettype wire

// ### clksw_pkg.sv
// constants shared by the clock switchover block
`default_nettype none
package clksw_pkg;
   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int POR_TIME_NS = 1000;
   localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STUCK_TIME_NS = 500;
   localparam int STUCK_CYCLES = STUCK_TIME_NS / CLK_PERIOD_NS;
   // ----------------------------------------
   // switchover stage lengths, power and stuck counts, counter constants
   // ----------------------------------------
   localparam logic [7:0] OLD_PULSES = 8'h02;
   localparam logic [7:0] NEW_HIGH_PULSES = 8'h02;
   localparam logic [7:0] NEW_LOW_FALLS = 8'h02;
   localparam logic [7:0] POR_COUNT = 8'(POR_CYCLES);
   localparam logic [7:0] STUCK_COUNT = 8'(STUCK_CYCLES);
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [7:0] CNT_ONE = 8'h01;
   // ----------------------------------------
   // sequencer states
   // ----------------------------------------
   typedef enum logic [1:0] {
      CLKSW_FOLLOW,
      CLKSW_OLD,
      CLKSW_HIGH,
      CLKSW_LOW
   } clksw_state_t;
endpackage : clksw_pkg
`default_nettype wire

// ### clksw_properties.sv
// port assertions for the clock switchover
`timescale 1ns/1ps
`default_nettype none
module clksw_properties
   import clksw_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic clock_input_zero,
   input wire logic clock_input_one,
   input wire logic amp_ok_zero,
   input wire logic amp_ok_one,
   input wire logic source_choice,
   input wire logic short_cycle_suppressor_off,
   input wire logic clock_out_q,
   input wire logic active_source_q,
   input wire logic switching_q,
   input wire logic ready_q
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   logic [7:0] cnt_q;
   wire logic sel_in = active_source_q ? clock_input_one : clock_input_zero;
   wire logic ok = active_source_q ? amp_ok_one : amp_ok_zero;
   // saturates so a long run never wraps back under the delay
   always_ff @(posedge clk) begin
      if (!rstn) cnt_q <= 8'h00;
      else if (ce && cnt_q != 8'hff) cnt_q <= cnt_q + 8'h01;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_reset_clears: assert property (disable iff (1'b0)
      !rstn |=> !clock_out_q && !switching_q && !ready_q) else $error("reset leak");
   a_ready_delay: assert property (ready_q |-> cnt_q >= POR_COUNT)
      else $error("ready early");
   a_quiet_early: assert property (!ready_q |-> !switching_q) else $error("early switch");
   a_bypass_quiet: assert property (short_cycle_suppressor_off |-> !switching_q)
      else $error("bypass seq");
   a_bypass_track: assert property (ready_q && short_cycle_suppressor_off
      && $changed(source_choice) |-> ##[1:4] active_source_q == source_choice)
      else $error("bypass slow");
   a_choice_taken: assert property (ready_q && !switching_q && !short_cycle_suppressor_off
      && $changed(source_choice) && source_choice != active_source_q |-> ##[1:4] switching_q)
      else $error("choice lost");
   a_source_at_end: assert property ($changed(active_source_q) && ready_q
      && !short_cycle_suppressor_off |-> $fell(switching_q)) else $error("source moved");
   a_seq_bounded: assert property ($rose(switching_q) |-> ##[1:300] !switching_q)
      else $error("seq hung");
   a_ends_low: assert property ($fell(switching_q) |-> !$past(clock_out_q))
      else $error("end not low");
   a_latch_dead: assert property ((ready_q && !switching_q && !ok) [*4]
      |-> $stable(clock_out_q)) else $error("dead moved");
   a_follow_src: assert property ((ready_q && !switching_q && ok
      && !short_cycle_suppressor_off) [*4] |-> clock_out_q == $past(sel_in, 2))
      else $error("not following");
endmodule : clksw_properties
bind clksw_top clksw_properties i_clksw_properties (.*);
`default_nettype wire

// ### clksw_src.sv
// source clock model for one switchover input
`timescale 1ns/1ps
`default_nettype none
module clksw_src (
   input wire logic clk,
   input wire logic run,
   input wire logic [3:0] half,
   output logic src_q
);
   logic [3:0] cnt_q;
   initial begin
      src_q = 1'b0;
      cnt_q = 4'h0;
   end
   // steady toggling, a stop holds the last level
   always @(posedge clk) begin
      if (run) begin
         cnt_q <= (cnt_q + 4'h1 >= half) ? 4'h0 : cnt_q + 4'h1;
         if (cnt_q + 4'h1 >= half) src_q <= ~src_q;
      end
   end
endmodule : clksw_src
`default_nettype wire

// ### clksw_top.sv
// glitch-free two-input clock switchover, inputs oversampled on clk
// Behaviour
// [R1] old clock stuck low: hold output low for some new-clock falls, then follow.
// [R2] low-swing old clock: take stuck high or low path from last valid level.
// [R3] floating or dead chosen input: output stays stable at a clean level.
// [R4] slowly degrading but toggling input is passed through unguarded.
// [R5] after reset, sequencer waits a power delay before any switchover.
// [R6] both running: follow old some pulses, hold low some new pulses, follow new.
// [R7] old stuck high: hold high some new pulses, low some falls, then follow.
// [R8] suppression strapped off: plain multiplexer, switches at once.
// [R9] chosen input below minimum swing: output latches last valid level.
// [R10] source choice synchronised before use; stage lengths vary by a few edges.
`timescale 1ns/1ps
`default_nettype none
module clksw_top (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic clock_input_zero,
   input wire logic clock_input_one,
   input wire logic amp_ok_zero,
   input wire logic amp_ok_one,
   input wire logic source_choice,
   input wire logic short_cycle_suppressor_off,
   output logic clock_out_q,
   output logic active_source_q,
   output logic switching_q,
   output logic ready_q
);
   import clksw_pkg::*;

   // ----------------------------------------
   // input monitors
   // ----------------------------------------
   logic [1:0] rise;
   logic [1:0] fall;
   logic [1:0] level;
   logic [1:0] stuck;

   // [R9] last valid level held
   clksw_edge_mon u_mon_zero (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .clk_sample(clock_input_zero),
      .amp_ok(amp_ok_zero),
      .rise_q(rise[0]),
      .fall_q(fall[0]),
      .level_q(level[0]),
      .stuck_q(stuck[0])
   );

   clksw_edge_mon u_mon_one (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .clk_sample(clock_input_one),
      .amp_ok(amp_ok_one),
      .rise_q(rise[1]),
      .fall_q(fall[1]),
      .level_q(level[1]),
      .stuck_q(stuck[1])
   );

   // ----------------------------------------
   // source choice synchroniser
   // ----------------------------------------
   logic sel_meta_q;
   logic sel_sync_q;

   // [R10] two-stage synchroniser
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sel_meta_q <= 1'b0;
         sel_sync_q <= 1'b0;
      end else if (ce) begin
         sel_meta_q <= source_choice;
         sel_sync_q <= sel_meta_q;
      end
   end

   // ----------------------------------------
   // power delay and strap capture
   // ----------------------------------------
   logic [7:0] por_cnt_q;
   logic strap_taken_q;
   logic bypass_q;

   // [R5] power delay count
   always_ff @(posedge clk) begin
      if (!rstn) begin
         por_cnt_q <= CNT_ZERO;
         ready_q <= 1'b0;
      end else if (ce) begin
         if (por_cnt_q != POR_COUNT) begin
            por_cnt_q <= por_cnt_q + CNT_ONE;
         end
         ready_q <= (por_cnt_q == POR_COUNT);
      end
   end

   // strap caught once after release so a reset never loads a pin value
   always_ff @(posedge clk) begin
      if (!rstn) begin
         strap_taken_q <= 1'b0;
         bypass_q <= 1'b0;
      end else if (ce && !strap_taken_q) begin
         strap_taken_q <= 1'b1;
         bypass_q <= short_cycle_suppressor_off;
      end
   end

   // ----------------------------------------
   // switchover sequencer
   // ----------------------------------------
   clksw_state_t state_q;
   clksw_state_t state_d;
   logic cur_q;
   logic cur_d;
   logic tgt_q;
   logic tgt_d;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic out_d;

   always_comb begin
      state_d = state_q;
      cur_d = cur_q;
      tgt_d = tgt_q;
      cnt_d = cnt_q;
      out_d = clock_out_q;
      if (!ready_q) begin
         // [R5] no switch before delay
         state_d = CLKSW_FOLLOW;
         cur_d = sel_sync_q;
         tgt_d = sel_sync_q;
         cnt_d = CNT_ZERO;
         out_d = 1'b0;
      end else if (bypass_q) begin
         // [R8] plain multiplexer
         state_d = CLKSW_FOLLOW;
         cur_d = sel_sync_q;
         tgt_d = sel_sync_q;
         cnt_d = CNT_ZERO;
         out_d = level[sel_sync_q];
      end else begin
         unique case (state_q)
            CLKSW_FOLLOW: begin
               // [R3] stable output from held level
               out_d = level[cur_q];
               cnt_d = CNT_ZERO;
               if (sel_sync_q != cur_q) begin
                  tgt_d = sel_sync_q;
                  if (!stuck[cur_q]) begin
                     // [R6] keep old clock first
                     state_d = CLKSW_OLD;
                  end else if (level[cur_q]) begin
                     // [R2] last level high
                     state_d = CLKSW_HIGH;
                     out_d = 1'b1;
                  end else begin
                     // [R1] last level low
                     state_d = CLKSW_LOW;
                     out_d = 1'b0;
                  end
               end
            end
            CLKSW_OLD: begin
               out_d = level[cur_q];
               if (stuck[cur_q]) begin
                  // [R2] old died mid-stage
                  cnt_d = CNT_ZERO;
                  state_d = level[cur_q] ? CLKSW_HIGH : CLKSW_LOW;
               end else if (fall[cur_q]) begin
                  if (cnt_q + CNT_ONE == OLD_PULSES) begin
                     // [R6] old ends low
                     cnt_d = CNT_ZERO;
                     state_d = CLKSW_LOW;
                     out_d = 1'b0;
                  end else begin
                     cnt_d = cnt_q + CNT_ONE;
                  end
               end
            end
            CLKSW_HIGH: begin
               // [R7] hold high on new pulses
               out_d = 1'b1;
               if (rise[tgt_q]) begin
                  if (cnt_q + CNT_ONE == NEW_HIGH_PULSES) begin
                     cnt_d = CNT_ZERO;
                     state_d = CLKSW_LOW;
                     out_d = 1'b0;
                  end else begin
                     cnt_d = cnt_q + CNT_ONE;
                  end
               end
            end
            CLKSW_LOW: begin
               // [R1] hold low on new falls
               out_d = 1'b0;
               if (fall[tgt_q]) begin
                  if (cnt_q + CNT_ONE == NEW_LOW_FALLS) begin
                     // release just after a fall, so the first new pulse is full
                     cnt_d = CNT_ZERO;
                     cur_d = tgt_q;
                     state_d = CLKSW_FOLLOW;
                  end else begin
                     cnt_d = cnt_q + CNT_ONE;
                  end
               end
            end
         endcase
      end
   end

   // a target that dies during the low hold leaves the output low until it runs again
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_q <= CLKSW_FOLLOW;
         cur_q <= 1'b0;
         tgt_q <= 1'b0;
         cnt_q <= CNT_ZERO;
      end else if (ce) begin
         state_q <= state_d;
         cur_q <= cur_d;
         tgt_q <= tgt_d;
         cnt_q <= cnt_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // [R4] toggling input passes as sampled, duty distortion not corrected
   always_ff @(posedge clk) begin
      if (!rstn) begin
         clock_out_q <= 1'b0;
         active_source_q <= 1'b0;
         switching_q <= 1'b0;
      end else if (ce) begin
         clock_out_q <= out_d;
         active_source_q <= cur_d;
         switching_q <= (state_d != CLKSW_FOLLOW);
      end
   end
endmodule : clksw_top
`default_nettype wire

// ### clksw_top_bench.sv
// self-checking bench for the clock switchover
`timescale 1ns/1ps
`default_nettype none
module clksw_top_bench;
   import clksw_pkg::*;
   logic clk = 0, rstn = 0, ce = 1, sel = 0, off = 0, a0 = 1, a1 = 1;
   logic r0 = 1, r1 = 1, chk = 0, exp_src = 0, v;
   logic [3:0] h0 = 4'h4, h1 = 4'h5;
   logic i0, i1, co, act, sw, rdy;
   logic q[$];
   int error_cnt = 0, n_compared = 0, k;
   initial forever #12.5 clk = ~clk;
   clksw_src i_clksw_src_0 (.clk(clk), .run(r0), .half(h0), .src_q(i0));
   clksw_src i_clksw_src_1 (.clk(clk), .run(r1), .half(h1), .src_q(i1));
   clksw_top i_clksw_top (.clk(clk), .rstn(rstn), .ce(ce), .clock_input_zero(i0),
      .clock_input_one(i1), .amp_ok_zero(a0), .amp_ok_one(a1), .source_choice(sel),
      .short_cycle_suppressor_off(off), .clock_out_q(co), .active_source_q(act),
      .switching_q(sw), .ready_q(rdy));
   // ----------------------------------------
   // tasks and follow model
   // ----------------------------------------
   task check(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task conclude();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task swap(input logic lvl, input logic use_lvl);
      chk = 0;
      sel = ~sel;
      k = 0;
      while (sw !== 1'b1 && k < 8) begin cyc(1); k++; end
      check(sw, 1'b1);
      if (use_lvl) check(co, lvl);
      k = 0;
      while (sw !== 1'b0 && k < 300) begin cyc(1); k++; end
      check(act, sel);
      exp_src = sel;
      cyc(3);
      chk = 1;
   endtask : swap
   // the chosen input two edges back is what the output shows
   // sampled mid-cycle so no read races the edge that launches the output
   always @(negedge clk) begin
      q.push_back(exp_src ? i1 : i0);
      if (q.size() > 3) void'(q.pop_front());
      if (chk && q.size() == 3) check(co, q[0]);
   end
   initial begin
      #400000;
      error_cnt++;
      conclude();
   end
   initial begin
      void'($urandom(32'h2adf_3650));
      h0 = 4'($urandom_range(3, 6));
      h1 = 4'($urandom_range(3, 6));
      cyc(4);
      rstn = 1;
      check(co, 1'b0);
      sel = 1;
      cyc(20);
      check(sw, 1'b0);
      sel = 0;
      k = 0;
      while (rdy !== 1'b1 && k < 80) begin cyc(1); k++; end
      check(rdy, 1'b1);
      $display("test reset done");
      cyc(3);
      chk = 1;
      cyc(30);
      swap(1'b0, 1'b0);
      $display("test running done");
      repeat (8) if (i1 !== 1'b1) cyc(1);
      r1 = 0;
      cyc(30);
      swap(1'b1, 1'b1);
      r1 = 1;
      repeat (8) if (i0 !== 1'b0) cyc(1);
      r0 = 0;
      cyc(30);
      swap(1'b0, 1'b1);
      r0 = 1;
      $display("test stuck done");
      chk = 0;
      a1 = 0;
      cyc(3);
      v = co;
      repeat (10) begin cyc(1); check(co, v); end
      swap(v, 1'b1);
      a1 = 1;
      $display("test low swing done");
      // old clock dies just before the choice moves, before it is flagged stuck: the sequence must leave the first stage
      r0 = 0;
      swap(1'b0, 1'b0);
      r0 = 1;
      $display("test mid-stage death done");
      chk = 0;
      rstn = 0;
      off = 1;
      cyc(4);
      rstn = 1;
      // power delay must not advance while the enable is low
      ce = 0;
      cyc(10);
      ce = 1;
      k = 0;
      while (rdy !== 1'b1 && k < 80) begin cyc(1); k++; end
      check(1'(k == POR_CYCLES + 1), 1'b1);
      $display("test freeze done");
      repeat (6) begin
         chk = 0;
         sel = 1'($urandom);
         cyc(3);
         exp_src = sel;
         cyc(3);
         chk = 1;
         cyc(4);
         check(sw, 1'b0);
         check(act, sel);
      end
      $display("test bypass done");
      conclude();
   end
endmodule : clksw_top_bench
`default_nettype wire
